// ### pll_prog_pkg.sv
// Shared constants for the synthesizer latch programming logic.
package pll_prog_pkg;

    // ------------------------------------------------------------
    // Serial word and latch selection
    // ------------------------------------------------------------
    localparam int         WORD_W      = 24;
    localparam int         SEL_W       = 2;
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_REF     = 2'h1;
    localparam logic [1:0] SEL_FEEDBK  = 2'h2;

    // ------------------------------------------------------------
    // Control word field positions and widths
    // ------------------------------------------------------------
    localparam int CORE_PWR_LSB = 2;
    localparam int CORE_PWR_W   = 2;
    localparam int CLEAR_BIT    = 4;
    localparam int DIVSEL_LSB   = 5;
    localparam int DIVSEL_W     = 3;
    localparam int POLARITY_BIT = 8;
    localparam int TRISTATE_BIT = 9;
    localparam int GAIN_CTL_BIT = 10;
    localparam int MUTE_BIT     = 11;
    localparam int OUT_PWR_LSB  = 12;
    localparam int OUT_PWR_W    = 2;
    localparam int CUR_A_LSB    = 14;
    localparam int CUR_B_LSB    = 17;
    localparam int CUR_W        = 3;
    localparam int PD_EN_BIT    = 20;
    localparam int PD_SYNC_BIT  = 21;

    // ------------------------------------------------------------
    // Feedback and reference word field positions and widths
    // ------------------------------------------------------------
    localparam int AUX_LSB     = 2;
    localparam int AUX_W       = 5;
    localparam int FB_LSB      = 8;
    localparam int FB_W        = 13;
    localparam int GAIN_FB_BIT = 21;
    localparam int REF_LSB     = 2;
    localparam int REF_W       = 14;

    // ------------------------------------------------------------
    // Legal ranges and reset values
    // ------------------------------------------------------------
    localparam logic [AUX_W-1:0]      AUX_OFF      = 5'h00;
    localparam logic [AUX_W-1:0]      AUX_MIN      = 5'h02;
    localparam logic [FB_W-1:0]       FB_MIN       = 13'h0003;
    localparam logic [REF_W-1:0]      REF_MIN      = 14'h0001;
    localparam logic [CUR_W-1:0]      CUR_RST      = 3'h0;
    localparam logic [OUT_PWR_W-1:0]  OUT_PWR_RST  = 2'h0;
    localparam logic [CORE_PWR_W-1:0] CORE_PWR_RST = 2'h0;
    localparam logic [DIVSEL_W-1:0]   DIVSEL_RST   = 3'h0;

    // Synchronous power-down fires on the reference-counter pulse seen while pd_edge_r equals this, the second pulse.
    localparam logic SYNC_PD_LAST = 1'b1;

    // ------------------------------------------------------------
    // Divided-output multiplexer codes
    // ------------------------------------------------------------
    localparam logic [2:0] DIVIDED_OUTPUT_LOW    = 3'h0;
    localparam logic [2:0] DIVIDED_OUTPUT_LOCK   = 3'h1;
    localparam logic [2:0] DIVIDED_OUTPUT_REFDIV = 3'h2;
    localparam logic [2:0] DIVIDED_OUTPUT_REFIN  = 3'h3;
    localparam logic [2:0] DIVIDED_OUTPUT_PDOWN  = 3'h4;
    localparam logic [2:0] DIVIDED_OUTPUT_RFEN   = 3'h5;
    localparam logic [2:0] DIVIDED_OUTPUT_HIZ    = 3'h6;

    // Power-down state machine.
    typedef enum logic [1:0] {PD_RUN, PD_WAIT_SYNC, PD_DOWN} pd_state_type;

endpackage : pll_prog_pkg

// ### pin_sync3.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ns
module pin_sync3
    import pll_prog_pkg::*;
(
    // Clock and reset
    input  wire logic CLK,
    input  wire logic NRST,
    // Asynchronous pin and filtered level
    input  wire logic PIN,
    output logic      LEVEL
);

    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Stage one feeds stage two only; the level follows once two and three agree.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            s1_r  <= 1'b0;
            s2_r  <= 1'b0;
            s3_r  <= 1'b0;
            LEVEL <= 1'b0;
        end
        else
        begin
            s1_r <= PIN;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
            begin
                LEVEL <= s3_r;
            end
        end
    end

endmodule : pin_sync3

// ### pll_control_latch.sv
// Serial latch programming and control-latch logic of the clock synthesizer.
//
// Notes on behaviour
// - Select bits 00 route word to control.
// - Enable one, sync zero: power down at once.
// - Both one: down on second reference pulse.
// - Power-down loads counters, tristates pump, clears lock.
// - Shift register keeps working while powered down.
// - Low three bits current A, high current B.
// - Two bits select oscillator output power.
// - Mute keeps RF off until lock.
// - Gain one selects current B, zero A.
// - Tristate bit holds pump in high impedance.
// - Polarity one positive, zero negative.
// - Three-bit field selects divided-output source.
// - Counter clear holds counters in reset.
// - Aux divider accepts 2 to 31, or 0.
// - Feedback counter accepts 3 to 8191.
// - Gain bit follows the latest write of either.
// - Shift on serial rising edge, latch on strobe.
`timescale 1ns/1ns
module pll_control_latch
    import pll_prog_pkg::*;
(
    // System clock and reset
    input  wire logic                  CLK,
    input  wire logic                  NRST,
    // Three-wire serial link
    input  wire logic                  SCLK,
    input  wire logic                  SDATA,
    input  wire logic                  LOAD_STROBE,
    // Reference input and loop lock report
    input  wire logic                  REF_IN,
    input  wire logic                  LOCK_IN,
    // Charge pump controls
    output logic [CUR_W-1:0]           PUMP_CURRENT_A,
    output logic [CUR_W-1:0]           PUMP_CURRENT_B,
    output logic [CUR_W-1:0]           PUMP_CURRENT,
    output logic                       PUMP_GAIN,
    output logic                       PUMP_HIZ,
    output logic                       DETECTOR_POLARITY,
    // Oscillator and output controls
    output logic [OUT_PWR_W-1:0]       OUTPUT_POWER,
    output logic [CORE_PWR_W-1:0]      CORE_POWER,
    output logic                       RF_ENABLE,
    output logic                       DIVIDED_OUTPUT,
    // Counter settings and status
    output logic [AUX_W-1:0]           AUX_DIVIDE,
    output logic [FB_W-1:0]            FEEDBACK_COUNT,
    output logic [REF_W-1:0]           REF_DIVIDE,
    output logic                       COUNTERS_HELD,
    output logic                       REF_COUNT_PULSE,
    output logic                       LOCK_DETECT,
    // Power state
    output logic                       POWERED_DOWN,
    output logic                       REF_BUFFER_EN
);

    // ------------------------------------------------------------
    // Link domain: serial shift register
    // ------------------------------------------------------------
    logic [WORD_W-1:0] shift_r;

    // Data enters on each rising serial clock, also while powered down.
    always_ff @(posedge SCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            shift_r <= '0;
        end
        else
        begin
            shift_r <= {shift_r[WORD_W-2:0], SDATA};
        end
    end

    AST_SHIFT_ALIVE: assert property (@(posedge SCLK) disable iff (!NRST)
        ##1 shift_r[0] == $past(SDATA))
        else $error("Serial shift register missed a data bit.");

    // ------------------------------------------------------------
    // Pin synchronisers into the system clock domain
    // ------------------------------------------------------------
    logic [2:0] pin_raw;
    logic [2:0] pin_lvl;

    assign pin_raw = {LOCK_IN, REF_IN, LOAD_STROBE};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            pin_sync3 u_sync (
                .CLK   (CLK),
                .NRST  (NRST),
                .PIN   (pin_raw[gi]),
                .LEVEL (pin_lvl[gi])
            );
        end
    endgenerate

    logic le_lvl;
    logic ref_lvl;
    logic lock_lvl;
    logic le_prev_r;
    logic ref_prev_r;
    logic le_rise;
    logic ref_rise;

    assign le_lvl   = pin_lvl[0];
    assign ref_lvl  = pin_lvl[1];
    assign lock_lvl = pin_lvl[2];

    // Edge history of the filtered strobe and reference.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            le_prev_r  <= 1'b0;
            ref_prev_r <= 1'b0;
        end
        else
        begin
            le_prev_r  <= le_lvl;
            ref_prev_r <= ref_lvl;
        end
    end

    assign le_rise  = le_lvl & ~le_prev_r;
    assign ref_rise = ref_lvl & ~ref_prev_r;

    // ------------------------------------------------------------
    // Latch decode: the shift register is still while the strobe is high
    // ------------------------------------------------------------
    logic wr_ctl;
    logic wr_fb;
    logic wr_ref;

    assign wr_ctl = le_rise && (shift_r[SEL_W-1:0] == SEL_CONTROL);
    assign wr_fb  = le_rise && (shift_r[SEL_W-1:0] == SEL_FEEDBK);
    assign wr_ref = le_rise && (shift_r[SEL_W-1:0] == SEL_REF);

    sequence ctl_load_seq;
        le_rise && shift_r[SEL_W-1:0] == SEL_CONTROL;
    endsequence

    // ------------------------------------------------------------
    // Control latch fields
    // ------------------------------------------------------------
    logic [CUR_W-1:0]      cur_a_r;
    logic [CUR_W-1:0]      cur_b_r;
    logic [OUT_PWR_W-1:0]  out_pwr_r;
    logic [CORE_PWR_W-1:0] core_pwr_r;
    logic [DIVSEL_W-1:0]   divsel_r;
    logic                  mute_r;
    logic                  tristate_r;
    logic                  polarity_r;
    logic                  clear_r;

    // Control word storage.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            cur_a_r    <= CUR_RST;
            cur_b_r    <= CUR_RST;
            out_pwr_r  <= OUT_PWR_RST;
            core_pwr_r <= CORE_PWR_RST;
            divsel_r   <= DIVSEL_RST;
            mute_r     <= 1'b0;
            tristate_r <= 1'b0;
            polarity_r <= 1'b0;
            clear_r    <= 1'b0;
        end
        else if (wr_ctl)
        begin
            cur_a_r    <= shift_r[CUR_A_LSB +: CUR_W];
            cur_b_r    <= shift_r[CUR_B_LSB +: CUR_W];
            out_pwr_r  <= shift_r[OUT_PWR_LSB +: OUT_PWR_W];
            core_pwr_r <= shift_r[CORE_PWR_LSB +: CORE_PWR_W];
            divsel_r   <= shift_r[DIVSEL_LSB +: DIVSEL_W];
            mute_r     <= shift_r[MUTE_BIT];
            tristate_r <= shift_r[TRISTATE_BIT];
            polarity_r <= shift_r[POLARITY_BIT];
            clear_r    <= shift_r[CLEAR_BIT];
        end
    end

    AST_CTRL_ROUTE: assert property (@(posedge CLK) disable iff (!NRST)
        ctl_load_seq |=> divsel_r == $past(shift_r[DIVSEL_LSB +: DIVSEL_W])
            && polarity_r == $past(shift_r[POLARITY_BIT]))
        else $error("Control word was not routed to the control latch.");

    // ------------------------------------------------------------
    // Feedback and reference latches, shared gain bit
    // ------------------------------------------------------------
    logic             gain_r;
    logic [AUX_W-1:0] aux_r;
    logic [FB_W-1:0]  fb_r;
    logic [REF_W-1:0] ref_div_r;
    logic [AUX_W-1:0] aux_new;
    logic [FB_W-1:0]  fb_new;
    logic [REF_W-1:0] ref_new;

    assign aux_new = shift_r[AUX_LSB +: AUX_W];
    assign fb_new  = shift_r[FB_LSB +: FB_W];
    assign ref_new = shift_r[REF_LSB +: REF_W];

    // Out-of-range divide values are ignored and the old value kept.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            aux_r     <= AUX_OFF;
            fb_r      <= FB_MIN;
            ref_div_r <= REF_MIN;
        end
        else
        begin
            if (wr_fb && (aux_new == AUX_OFF || aux_new >= AUX_MIN))
            begin
                aux_r <= aux_new;
            end
            if (wr_fb && fb_new >= FB_MIN)
            begin
                fb_r <= fb_new;
            end
            if (wr_ref && ref_new >= REF_MIN)
            begin
                ref_div_r <= ref_new;
            end
        end
    end

    // Gain bit takes whichever of the control and feedback latches was written last.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            gain_r <= 1'b0;
        end
        else if (wr_ctl)
        begin
            gain_r <= shift_r[GAIN_CTL_BIT];
        end
        else if (wr_fb)
        begin
            gain_r <= shift_r[GAIN_FB_BIT];
        end
    end

    AST_GAIN_LATEST: assert property (@(posedge CLK) disable iff (!NRST)
        wr_fb |=> gain_r == $past(shift_r[GAIN_FB_BIT]))
        else $error("Gain bit did not follow the feedback word.");

    AST_FB_RANGE: assert property (@(posedge CLK) disable iff (!NRST)
        fb_r >= FB_MIN && (aux_r == AUX_OFF || aux_r >= AUX_MIN))
        else $error("Divider holds an illegal value.");

    // ------------------------------------------------------------
    // Power-down state machine
    // ------------------------------------------------------------
    pd_state_type pd_state_r;
    pd_state_type pd_state_nxt;
    logic         pd_edge_r;
    logic         ref_pulse_r;

    // Decide the next power state from control writes and reference pulses.
    always_comb
    begin
        pd_state_nxt = pd_state_r;
        if (wr_ctl)
        begin
            if (!shift_r[PD_EN_BIT])
            begin
                pd_state_nxt = PD_RUN;
            end
            else if (!shift_r[PD_SYNC_BIT])
            begin
                pd_state_nxt = PD_DOWN;
            end
            else if (pd_state_r != PD_DOWN)
            begin
                pd_state_nxt = PD_WAIT_SYNC;
            end
        end
        else
        begin
            case (pd_state_r)
                PD_WAIT_SYNC:
                begin
                    if (ref_pulse_r && pd_edge_r == SYNC_PD_LAST)
                    begin
                        pd_state_nxt = PD_DOWN;
                    end
                end
                PD_RUN:  pd_state_nxt = PD_RUN;
                PD_DOWN: pd_state_nxt = PD_DOWN;
                default: pd_state_nxt = PD_DOWN;
            endcase
        end
    end

    // State register; reset leaves the part down until a control write clears the enable bit.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pd_state_r <= PD_DOWN;
        end
        else
        begin
            pd_state_r <= pd_state_nxt;
        end
    end

    // Counts reference pulses seen since the synchronous request.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pd_edge_r <= 1'b0;
        end
        else if (wr_ctl)
        begin
            pd_edge_r <= 1'b0;
        end
        else if (pd_state_r == PD_WAIT_SYNC && ref_pulse_r)
        begin
            pd_edge_r <= ~pd_edge_r;
        end
    end

    logic pd_now;
    assign pd_now = (pd_state_r == PD_DOWN);

    AST_ASYNC_PD: assert property (@(posedge CLK) disable iff (!NRST)
        ctl_load_seq ##0 (shift_r[PD_EN_BIT] && !shift_r[PD_SYNC_BIT])
            |=> pd_now ##1 POWERED_DOWN)
        else $error("Asynchronous power-down did not take effect.");

    sequence sync_req_seq;
        ctl_load_seq ##0 (shift_r[PD_EN_BIT] && shift_r[PD_SYNC_BIT] && !pd_now);
    endsequence

    AST_SYNC_PD: assert property (@(posedge CLK) disable iff (!NRST)
        sync_req_seq |=> pd_state_r == PD_WAIT_SYNC && !pd_now)
        else $error("Synchronous power-down did not wait for the reference.");

    AST_SYNC_PD_FIRE: assert property (@(posedge CLK) disable iff (!NRST)
        (pd_state_r == PD_WAIT_SYNC && ref_pulse_r && pd_edge_r && !wr_ctl) |=> pd_now)
        else $error("Power-down missed the second reference pulse.");

    AST_RELEASE: assert property (@(posedge CLK) disable iff (!NRST)
        ctl_load_seq ##0 !shift_r[PD_EN_BIT] |=> pd_state_r == PD_RUN)
        else $error("Clearing the enable bit did not release power-down.");

    // ------------------------------------------------------------
    // Reference counter
    // ------------------------------------------------------------
    logic [REF_W-1:0] ref_cnt_r;
    logic             hold_cnt;
    logic             ref_buf_r;

    assign hold_cnt = clear_r | pd_now;

    // Counts reference edges down; held at its load value when cleared.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ref_cnt_r   <= REF_MIN;
            ref_pulse_r <= 1'b0;
        end
        else if (hold_cnt)
        begin
            ref_cnt_r   <= ref_div_r;
            ref_pulse_r <= 1'b0;
        end
        else if (ref_rise && ref_buf_r)
        begin
            ref_pulse_r <= (ref_cnt_r <= REF_MIN);
            ref_cnt_r   <= (ref_cnt_r <= REF_MIN) ? ref_div_r : ref_cnt_r - REF_MIN;
        end
        else
        begin
            ref_pulse_r <= 1'b0;
        end
    end

    AST_CLEAR: assert property (@(posedge CLK) disable iff (!NRST)
        clear_r |=> ref_cnt_r == $past(ref_div_r) && !ref_pulse_r)
        else $error("Counter clear did not hold the reference counter.");

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    logic lock_r;
    logic rf_en_nxt;
    logic div_nxt;

    assign rf_en_nxt = ~pd_now & (~mute_r | lock_r);

    // Divided-output multiplexer source.
    always_comb
    begin
        case (divsel_r)
            DIVIDED_OUTPUT_LOW:    div_nxt = 1'b0;
            DIVIDED_OUTPUT_LOCK:   div_nxt = lock_r;
            DIVIDED_OUTPUT_REFDIV: div_nxt = ref_pulse_r;
            DIVIDED_OUTPUT_REFIN:  div_nxt = ref_lvl & ref_buf_r;
            DIVIDED_OUTPUT_PDOWN:  div_nxt = pd_now;
            DIVIDED_OUTPUT_RFEN:   div_nxt = rf_en_nxt;
            DIVIDED_OUTPUT_HIZ:    div_nxt = PUMP_HIZ;
            default:       div_nxt = 1'b1;
        endcase
    end

    // All outputs leave flip-flops.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ref_buf_r         <= 1'b0;
            lock_r            <= 1'b0;
            PUMP_CURRENT_A    <= CUR_RST;
            PUMP_CURRENT_B    <= CUR_RST;
            PUMP_CURRENT      <= CUR_RST;
            PUMP_GAIN         <= 1'b0;
            PUMP_HIZ          <= 1'b1;
            DETECTOR_POLARITY <= 1'b0;
            OUTPUT_POWER      <= OUT_PWR_RST;
            CORE_POWER        <= CORE_PWR_RST;
            RF_ENABLE         <= 1'b0;
            DIVIDED_OUTPUT    <= 1'b0;
            AUX_DIVIDE        <= AUX_OFF;
            FEEDBACK_COUNT    <= FB_MIN;
            REF_DIVIDE        <= REF_MIN;
            COUNTERS_HELD     <= 1'b1;
            REF_COUNT_PULSE   <= 1'b0;
            LOCK_DETECT       <= 1'b0;
            POWERED_DOWN      <= 1'b1;
            REF_BUFFER_EN     <= 1'b0;
        end
        else
        begin
            ref_buf_r         <= ~pd_now;
            lock_r            <= lock_lvl & ~pd_now;
            PUMP_CURRENT_A    <= cur_a_r;
            PUMP_CURRENT_B    <= cur_b_r;
            PUMP_CURRENT      <= gain_r ? cur_b_r : cur_a_r;
            PUMP_GAIN         <= gain_r;
            PUMP_HIZ          <= tristate_r | pd_now;
            DETECTOR_POLARITY <= polarity_r;
            OUTPUT_POWER      <= out_pwr_r;
            CORE_POWER        <= core_pwr_r;
            RF_ENABLE         <= rf_en_nxt;
            DIVIDED_OUTPUT    <= div_nxt;
            AUX_DIVIDE        <= aux_r;
            FEEDBACK_COUNT    <= fb_r;
            REF_DIVIDE        <= ref_div_r;
            COUNTERS_HELD     <= hold_cnt;
            REF_COUNT_PULSE   <= ref_pulse_r;
            LOCK_DETECT       <= lock_r;
            POWERED_DOWN      <= pd_now;
            REF_BUFFER_EN     <= ref_buf_r;
        end
    end

    AST_PD_EFFECTS: assert property (@(posedge CLK) disable iff (!NRST)
        pd_now ##1 pd_now |-> PUMP_HIZ && !ref_buf_r && !lock_r && COUNTERS_HELD)
        else $error("Power-down effects are incomplete.");

    AST_MUTE: assert property (@(posedge CLK) disable iff (!NRST)
        (mute_r && !lock_r) |=> !RF_ENABLE)
        else $error("RF output enabled before lock while muted.");

    AST_GAIN_SEL: assert property (@(posedge CLK) disable iff (!NRST)
        ##1 PUMP_CURRENT == ($past(gain_r) ? $past(cur_b_r) : $past(cur_a_r)))
        else $error("Pump current does not follow the gain bit.");

    AST_TRISTATE: assert property (@(posedge CLK) disable iff (!NRST)
        tristate_r |=> PUMP_HIZ)
        else $error("Pump left driving with tristate bit set.");

endmodule : pll_control_latch

// ### pll_host_model.sv
// Host model driving the three-wire serial link of the synthesizer.
`timescale 1ns/1ns
module pll_host_model
    import pll_prog_pkg::*;
(
    // Serial link
    output logic SCLK,
    output logic SDATA,
    output logic LOAD_STROBE
);
    // The link idles with its clock and strobe low.
    initial
    begin
        SCLK = 1'b0;
        SDATA = 1'b0;
        LOAD_STROBE = 1'b0;
    end

    // Shifts a word MSB first at a 48 ns bit period, then strobes it in.
    task automatic send_word(input logic [WORD_W-1:0] w);
        for (int i = WORD_W - 1; i >= 0; i--)
        begin
            SDATA = w[i];
            #24 SCLK = 1'b1;
            #24 SCLK = 1'b0;
        end
        SDATA = ~w[0]; // Data no longer held once the word is shifted.
        #100 LOAD_STROBE = 1'b1;
        #200 LOAD_STROBE = 1'b0;
        #200;
    endtask : send_word
endmodule : pll_host_model

// ### pll_control_latch_tb.sv
// Self-checking bench for the control-latch programming logic.
`timescale 1ns/1ns
module pll_control_latch_tb
    import pll_prog_pkg::*;
;
    localparam int SETTLE_NS = 600000; // Settling wait for the small noise capacitor.
    logic clk, nrst, sclk, sdata, ld, ref_in, lock_in, ref_run;
    logic [2:0] ca, cb, cur;
    logic [1:0] opw, cpw;
    logic [4:0] aux;
    logic [12:0] fb;
    logic [13:0] refd;
    logic gain, hiz, pol, rfen, divo, held, rp, lockd, pdn, rbuf;
    int mismatches = 0;
    int n_tests = 0;
    logic [4:0] fba [2] = '{5'h02, 5'h1f};
    logic [12:0] fbb [2] = '{13'h0003, 13'h1fff};
    logic fbg [2] = '{1'b0, 1'b1};

    pll_host_model i_pll_host_model (.SCLK(sclk), .SDATA(sdata), .LOAD_STROBE(ld));
    pll_control_latch i_pll_control_latch (.CLK(clk), .NRST(nrst), .SCLK(sclk),
        .SDATA(sdata), .LOAD_STROBE(ld), .REF_IN(ref_in), .LOCK_IN(lock_in),
        .PUMP_CURRENT_A(ca), .PUMP_CURRENT_B(cb), .PUMP_CURRENT(cur), .PUMP_GAIN(gain),
        .PUMP_HIZ(hiz), .DETECTOR_POLARITY(pol), .OUTPUT_POWER(opw), .CORE_POWER(cpw),
        .RF_ENABLE(rfen), .DIVIDED_OUTPUT(divo), .AUX_DIVIDE(aux), .FEEDBACK_COUNT(fb),
        .REF_DIVIDE(refd), .COUNTERS_HELD(held), .REF_COUNT_PULSE(rp),
        .LOCK_DETECT(lockd), .POWERED_DOWN(pdn), .REF_BUFFER_EN(rbuf));

    // Clocks: system clock and a gated 5 MHz reference.
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always #100 ref_in = ref_run & ~ref_in;

    // Compares a value and reports a mismatch.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp)
            mismatches++;
    endtask : chk

    // Builds a control word from its fields.
    function automatic logic [23:0] cw(input logic [1:0] pd, input logic [5:0] cu,
        input logic [3:0] fl, input logic [2:0] ds, input logic cr);
        return {2'h0, pd, cu, 2'h2, fl, ds, cr, 2'h1, SEL_CONTROL};
    endfunction : cw

    // Waits, with a bound, until one reference-counter pulse has passed.
    task automatic wait_pulse();
        for (int k = 0; k < 400 && rp !== 1'b1; k++) @(negedge clk);
        @(negedge clk);
    endtask : wait_pulse

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    // Cuts a hang short well beyond the expected run time.
    initial
    begin
        #1000000 mismatches++;
        stop_test();
    end

    // Test sequence.
    initial
    begin
        {nrst, ref_in, lock_in, ref_run} = 4'h0;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        chk(pdn, 1);
        chk(fb, 3);
        $display("test reset done");
        i_pll_host_model.send_word({8'h0, 14'h0007, SEL_REF});
        i_pll_host_model.send_word(cw(2'h0, 6'o53, 4'h5, 3'h7, 1'b0));
        #(SETTLE_NS);
        chk(ca, 3);
        chk(cb, 5);
        chk(cur, 5);
        chk(pol, 1);
        chk(opw, 2);
        chk(cpw, 1);
        chk(gain, 1);
        chk(divo, 1);
        foreach (fba[i])
        begin
            i_pll_host_model.send_word({2'h0, fbg[i], fbb[i], 1'b0, fba[i], SEL_FEEDBK});
            chk(aux, fba[i]);
            chk(fb, fbb[i]);
            chk(cur, fbg[i] ? 3'h5 : 3'h3);
            chk(gain, fbg[i]);
        end
        i_pll_host_model.send_word(cw(2'h0, 6'o53, 4'ha, 3'h6, 1'b1));
        chk(rfen, 0);
        chk(hiz, 1);
        chk(held, 1);
        chk(divo, 1);
        @(negedge clk) lock_in = 1'b1;
        repeat (8) @(negedge clk);
        chk(rfen, 1);
        $display("test fields done");
        i_pll_host_model.send_word(cw(2'h1, 6'o53, 4'h4, 3'h0, 1'b0));
        chk(pdn, 1);
        chk(lockd, 0);
        chk(rbuf, 0);
        chk(divo, 0);
        i_pll_host_model.send_word({8'h0, 14'h0009, SEL_REF});
        chk(refd, 14'h0009);
        i_pll_host_model.send_word(cw(2'h0, 6'o53, 4'h4, 3'h0, 1'b0));
        chk(pdn, 0);
        chk(fb, 13'h1fff);
        $display("test async power-down done");
        i_pll_host_model.send_word(cw(2'h3, 6'o53, 4'h4, 3'h4, 1'b0));
        ref_run = 1'b1;
        wait_pulse();
        chk(pdn, 0);
        chk(divo, 0);
        wait_pulse();
        repeat (3) @(negedge clk);
        chk(pdn, 1);
        chk(hiz, 1);
        chk(divo, 1);
        $display("test sync power-down done");
        stop_test();
    end
endmodule : pll_control_latch_tb
